// file: core/motion_permit_interlock.sv
// Summary of operation
// - Guarded spindle: permit starts false, key raises
// - Raised spindle permit holds while door closed
// - Handwheel: permissive with jog or start edge
// - Panel: permissive with jog or start edge
// - Magazine door also open forces spindle false
// - Magazine open: permissive plus exactly one key
// - Magazine closed: permit true regardless of motion keys
// - Closed magazine optionally gated by confirmation key
// - One feed flag per axis, one per group
// - NC space closed: axis feed permit true
// - Panel: feed while running or direction key
// - Handwheel: feed while running or permissive held
// - Single spindle: feed slot 18 always true
// - Aux axis: guarded true, else direction key
// - One stop word per group, fixed codes
// - Codes select fatal, emergency, delayed, contour, none
// - Block group by contour stop, axis by feed
// - Fully guarded group requests no deceleration
// - Clear run flag after one second idle
// - Stop request may last one cycle only
`timescale 1ns/1ps
`default_nettype none
module motion_permit_interlock
  import interlock_pkg::*;
#(
  parameter int unsigned RUN_CLEAR_CYCLES = RUN_CLEAR_CYCLES_DEF  // Idle time before run clears
) (
  input  wire logic                                    core_clk,
  input  wire logic                                    sys_rst,
  input  wire logic                                    spindle_guarded,
  input  wire logic                                    nc_guarded,
  input  wire logic                                    aux_guarded,
  input  wire logic                                    single_spindle,
  input  wire logic                                    confirm_required,
  input  wire logic                                    spindle_door_closed,
  input  wire logic                                    nc_door_closed,
  input  wire logic                                    magazine_door_closed,
  input  wire logic [1:0]                              safe_mode,
  input  wire logic                                    handwheel_operation,
  input  wire logic                                    spindle_jog,
  input  wire logic                                    spindle_start,
  input  wire logic                                    nc_start,
  input  wire logic                                    hw_permissive,
  input  wire logic                                    panel_permissive,
  input  wire logic                                    stop_key,
  input  wire logic                                    ext_stop,
  input  wire logic                                    magazine_permissive,
  input  wire logic                                    magazine_confirm,
  input  wire logic [MAG_KEY_COUNT-1:0]                magazine_motion_keys,
  input  wire logic [NC_AXIS_COUNT-1:0]                nc_dir_keys,
  input  wire logic [AUX_AXIS_COUNT-1:0]               aux_dir_keys,
  input  wire logic                                    nc_group_idle,
  output logic      [MOTION_GROUPS-1:0]                group_motion_permit,
  output logic      [FEED_WIDTH-1:0]                   axis_feed_permit,
  output logic      [STOP_GROUPS-1:0][STOP_W-1:0]      group_stop_request,
  output logic                                         program_run_flag
);

  // Whole state of the interlock in one record
  typedef struct packed {
    logic                              start_prev;    // Spindle start, previous sample
    logic                              nc_start_prev; // NC start, previous sample
    logic                              jog_prev;      // Spindle jog, previous sample
    logic                              start_held;    // Start seen rising, still held
    logic                              spindle_armed; // Key pressed since door closed
    logic                              mag_confirmed; // Nobody-inside confirmed
    logic [1:0]                        mode_prev;     // Safe mode, previous sample
    logic                              run;           // Program-run flag
    logic [RUN_CNT_W-1:0]              idle_cnt;      // Cycles of continuous idle
    logic [MOTION_GROUPS-1:0]          motion;        // Group motion permits
    logic [FEED_WIDTH-1:0]             feed;          // Axis feed permits
    logic [STOP_GROUPS-1:0][STOP_W-1:0] stop;         // Stop request words
  } state_type;

  localparam logic [RUN_CNT_W-1:0] IDLE_LAST = RUN_CNT_W'(RUN_CLEAR_CYCLES - 1);

  pin_bus_if pins ();  // Pin sample to synchroniser and back
  pin_in_type s;       // Synchronised pin view
  state_type  q;       // Registered state
  state_type  d;       // Next state

  logic sp_full;       // Spindle space completely protected right now
  logic nc_full;       // NC space completely protected right now
  logic aux_full;      // Magazine space completely protected right now
  logic mode_ok;       // Safe mode two, three or four
  logic perm_sel;      // Permissive of the active operating source
  logic start_rise;    // Spindle start rising edge
  logic nc_rise;       // NC start rising edge
  logic jog_fall;      // Spindle jog released
  logic mode_change;   // Safe mode switched since last cycle
  logic mag_one_key;   // Exactly one magazine motion key
  logic run_set;       // Accepted start or guarded-door activation
  logic run_clear;     // Idle timeout reached
  logic run_dropped;   // Run flag falls this cycle

  // Gather every pin into one sample for the synchroniser
  assign pins.raw = '{spindle_guarded, nc_guarded, aux_guarded, single_spindle,
                      confirm_required, spindle_door_closed, nc_door_closed,
                      magazine_door_closed, safe_mode, handwheel_operation, spindle_jog,
                      spindle_start, nc_start, hw_permissive, panel_permissive, stop_key,
                      ext_stop, magazine_permissive, magazine_confirm,
                      magazine_motion_keys, nc_dir_keys, aux_dir_keys, nc_group_idle};

  // All pins are foreign to core_clk, so two flops before any use
  pin_sync #(
    .WIDTH ($bits(pin_in_type))
  ) u_pin_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .bus      (pins.sync_side)
  );

  assign s = pins.synced;

  // Decoded conditions shared by the evaluation below
  always_comb begin
    sp_full     = s.spindle_guarded & s.spindle_door_closed;
    nc_full     = s.nc_guarded & s.nc_door_closed;
    aux_full    = s.aux_guarded & s.magazine_door_closed;
    mode_ok     = (s.safe_mode == SAFE_MODE_TWO) || (s.safe_mode == SAFE_MODE_THREE) ||
                  (s.safe_mode == SAFE_MODE_FOUR);
    perm_sel    = s.handwheel_operation ? s.hw_permissive : s.panel_permissive;
    start_rise  = s.spindle_start & ~q.start_prev;
    nc_rise     = s.nc_start & ~q.nc_start_prev;
    jog_fall    = q.jog_prev & ~s.spindle_jog;
    mode_change = s.safe_mode != q.mode_prev;
    mag_one_key = $onehot(s.magazine_motion_keys);
    run_set     = (nc_rise & perm_sel) | nc_full;
    run_clear   = s.nc_group_idle && (q.idle_cnt == IDLE_LAST);
    run_dropped = q.run & ~(run_set | (q.run & ~run_clear));
  end

  // One evaluation pass per cycle fills the whole next state
  always_comb begin
    d = q;
    d.start_prev    = s.spindle_start;
    d.nc_start_prev = s.nc_start;
    d.jog_prev      = s.spindle_jog;
    d.mode_prev     = s.safe_mode;

    // Start counts as pressed from its edge until start or permissive lets go
    d.start_held = perm_sel & s.spindle_start & (q.start_held | start_rise);
    // Arming needs a key after the door closed; closing alone never arms
    d.spindle_armed = s.spindle_door_closed & (q.spindle_armed | s.spindle_jog |
                      s.spindle_start | s.nc_start | s.hw_permissive);
    d.mag_confirmed = s.magazine_door_closed & (q.mag_confirmed | s.magazine_confirm);

    // Idle counter restarts whenever the kernel reports the group not idle
    if (!s.nc_group_idle) begin
      d.idle_cnt = '0;
    end else if (q.idle_cnt != IDLE_LAST) begin
      d.idle_cnt = q.idle_cnt + RUN_CNT_W'(1);
    end
    // A set in the clearing cycle wins
    d.run = run_set | (q.run & ~run_clear);

    // Spindle group motion permit
    if (s.spindle_guarded) begin
      d.motion[MPERM_SPINDLE] = d.spindle_armed;
    end else if (!s.spindle_door_closed && !s.magazine_door_closed) begin
      d.motion[MPERM_SPINDLE] = 1'b0;
    end else begin
      // Same key rule for either source, only the permissive differs
      d.motion[MPERM_SPINDLE] = mode_ok & perm_sel &
                                (s.spindle_jog | d.start_held);
    end

    // Magazine group motion permit; closing may start pending moves
    if (s.magazine_door_closed) begin
      d.motion[MPERM_MAGAZINE] = ~s.confirm_required | d.mag_confirmed;
    end else begin
      d.motion[MPERM_MAGAZINE] = s.magazine_permissive & mag_one_key;
    end

    // Axis feed permits; unused slots stay off
    d.feed = '0;
    for (int i = 0; i < NC_AXIS_COUNT; i++) begin
      if (nc_full) begin
        d.feed[NC_AXIS_BASE + i] = 1'b1;
      end else if (s.handwheel_operation) begin
        d.feed[NC_AXIS_BASE + i] = d.run | s.hw_permissive;
      end else begin
        d.feed[NC_AXIS_BASE + i] = d.run | s.nc_dir_keys[i];
      end
    end
    // Several spindles follow the group permit; the kernel caps axis count
    d.feed[SPINDLE_FEED_IDX] = s.single_spindle | d.motion[MPERM_SPINDLE];
    for (int j = 0; j < AUX_AXIS_COUNT; j++) begin
      d.feed[AUX_AXIS_BASE + j] = aux_full | s.aux_dir_keys[j];
    end

    // Stop words; none unless an event below asks otherwise
    d.stop = {STOP_GROUPS{STOP_NONE}};
    // NC group: run drop gives a single-cycle contour stop
    if (!nc_full) begin
      if (s.stop_key | s.ext_stop | ~s.magazine_door_closed | mode_change |
          run_dropped) begin
        d.stop[STOP_NC] = STOP_CONTOUR_BRAKING;
      end
    end else begin
      d.stop[STOP_NC] = STOP_NONE;
    end
    // Spindle group: contour events take precedence over the magazine door
    if (!sp_full && mode_ok) begin
      if (s.stop_key | s.ext_stop | jog_fall | mode_change) begin
        d.stop[STOP_SPINDLE] = STOP_CONTOUR_BRAKING;
      end else if (!s.magazine_door_closed) begin
        d.stop[STOP_SPINDLE] = STOP_DELAYED_RAMP;
      end
    end
    // Magazine group: no stop keys, door opening in motion is an emergency
    if (aux_full) begin
      d.stop[STOP_MAGAZINE] = STOP_NONE;
    end else if (!s.magazine_door_closed && q.motion[MPERM_MAGAZINE] &&
                 !s.magazine_permissive) begin
      d.stop[STOP_MAGAZINE] = STOP_EMERGENCY_RAMP;
    end else if (mode_change) begin
      d.stop[STOP_MAGAZINE] = STOP_CONTOUR_BRAKING;
    end else if (s.magazine_permissive && mag_one_key) begin
      d.stop[STOP_MAGAZINE] = STOP_NONE;
    end else if (!s.magazine_door_closed) begin
      d.stop[STOP_MAGAZINE] = STOP_CONTOUR_BRAKING;
    end
  end

  // Register the evaluation; reset blocks all motion until first pass
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q      <= '0;
      q.stop <= {STOP_GROUPS{STOP_CONTOUR_BRAKING}};
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flip-flops
  assign group_motion_permit = q.motion;
  assign axis_feed_permit    = q.feed;
  assign group_stop_request  = q.stop;
  assign program_run_flag    = q.run;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // Guarded spindle with door open never permits
  property p_spindle_open_false;
    s.spindle_guarded && !s.spindle_door_closed |=> !group_motion_permit[MPERM_SPINDLE];
  endproperty
  a_spindle_open_false: assert property (p_spindle_open_false)
    else $error("guarded spindle permit with door open");

  // Armed spindle stays permitted while the door stays closed
  property p_spindle_hold;
    s.spindle_guarded && s.spindle_door_closed && q.spindle_armed
      |=> group_motion_permit[MPERM_SPINDLE];
  endproperty
  a_spindle_hold: assert property (p_spindle_hold)
    else $error("armed spindle permit dropped with door closed");

  // Handwheel jog with permissive in mode two permits the spindle
  property p_hw_jog;
    !s.spindle_guarded && s.spindle_door_closed && s.handwheel_operation &&
    s.hw_permissive && s.spindle_jog && s.safe_mode == SAFE_MODE_TWO
      |=> group_motion_permit[MPERM_SPINDLE];
  endproperty
  a_hw_jog: assert property (p_hw_jog)
    else $error("handwheel jog did not permit spindle");

  // Both doors open block the unguarded spindle
  property p_t_door;
    !s.spindle_guarded && !s.spindle_door_closed && !s.magazine_door_closed
      |=> !group_motion_permit[MPERM_SPINDLE];
  endproperty
  a_t_door: assert property (p_t_door)
    else $error("spindle permitted with magazine door open");

  // Open magazine needs exactly one motion key
  property p_mag_keys;
    !s.magazine_door_closed && !$onehot(s.magazine_motion_keys)
      |=> !group_motion_permit[MPERM_MAGAZINE];
  endproperty
  a_mag_keys: assert property (p_mag_keys)
    else $error("magazine permit without single motion key");

  // Closed magazine without confirmation duty is permitted
  property p_mag_closed;
    s.magazine_door_closed && !s.confirm_required |=> group_motion_permit[MPERM_MAGAZINE];
  endproperty
  a_mag_closed: assert property (p_mag_closed)
    else $error("closed magazine not permitted");

  // Closed NC space enables every NC axis
  property p_nc_feed;
    s.nc_guarded && s.nc_door_closed
      |=> &axis_feed_permit[NC_AXIS_BASE +: NC_AXIS_COUNT];
  endproperty
  a_nc_feed: assert property (p_nc_feed)
    else $error("NC feed missing with space closed");

  // Single spindle feed slot always set
  property p_single_spindle;
    s.single_spindle |=> axis_feed_permit[SPINDLE_FEED_IDX];
  endproperty
  a_single_spindle: assert property (p_single_spindle)
    else $error("spindle feed slot clear on single-spindle machine");

  // Unguarded aux axis follows its direction key
  property p_aux_feed;
    !(s.aux_guarded && s.magazine_door_closed)
      |=> axis_feed_permit[AUX_AXIS_BASE] == $past(s.aux_dir_keys[0]);
  endproperty
  a_aux_feed: assert property (p_aux_feed)
    else $error("aux feed does not follow direction key");

  // Guarded spindle space requests no deceleration
  property p_stop_none;
    s.spindle_guarded && s.spindle_door_closed
      |=> group_stop_request[STOP_SPINDLE] == STOP_NONE;
  endproperty
  a_stop_none: assert property (p_stop_none)
    else $error("guarded spindle group has a stop request");

  // Idle timeout without a set clears the run flag
  property p_run_clear;
    run_clear && !run_set |=> !program_run_flag;
  endproperty
  a_run_clear: assert property (p_run_clear)
    else $error("run flag survived idle timeout");

  c_spindle_edge: cover property (start_rise && perm_sel ##1 group_motion_permit[MPERM_SPINDLE]);
  c_mag_emergency: cover property (group_stop_request[STOP_MAGAZINE] == STOP_EMERGENCY_RAMP);
  c_run_drop: cover property (program_run_flag ##1 !program_run_flag);

endmodule : motion_permit_interlock
`default_nettype wire

// file: core/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import interlock_pkg::*;
#(
  parameter int WIDTH = $bits(pin_in_type)
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  pin_bus_if.sync_side    bus
);

  // Two stages; the first feeds only the second
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_type;

  sync_state_type q;  // Registered state
  sync_state_type d;  // Next state

  // Shift the pin sample through both stages
  always_comb begin
    d.meta   = bus.raw;
    d.stable = q.meta;
  end

  // Reset clears both stages to a constant
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.synced = q.stable;

endmodule : pin_sync
`default_nettype wire

// file: include/interlock_pkg.sv
package interlock_pkg;

  // Feed-permit array layout
  localparam int FEED_WIDTH       = 24;   // One flag per axis index
  localparam int NC_AXIS_BASE     = 0;    // First NC axis index
  localparam int NC_AXIS_COUNT    = 8;    // NC axes served here
  localparam int SPINDLE_FEED_IDX = 18;   // Spindle slot in the feed array
  localparam int AUX_AXIS_BASE    = 19;   // First magazine axis index
  localparam int AUX_AXIS_COUNT   = 4;    // Magazine axes, one direction key each
  localparam int MAG_KEY_COUNT    = 4;    // Magazine motion keys

  // Motion-permit group indices
  localparam int MOTION_GROUPS    = 2;
  localparam int MPERM_SPINDLE    = 0;
  localparam int MPERM_MAGAZINE   = 1;

  // Stop-request group indices
  localparam int STOP_GROUPS      = 3;
  localparam int STOP_NC          = 0;
  localparam int STOP_SPINDLE     = 1;
  localparam int STOP_MAGAZINE    = 2;

  // Stop codes, one word each; values are arbitrary but fixed
  localparam int STOP_W = 32;
  localparam logic [STOP_W-1:0] STOP_NONE            = 32'h0000_0000;
  localparam logic [STOP_W-1:0] STOP_FATAL_RAMP      = 32'h0000_0001;
  localparam logic [STOP_W-1:0] STOP_EMERGENCY_RAMP  = 32'h0000_0002;
  localparam logic [STOP_W-1:0] STOP_DELAYED_RAMP    = 32'h0000_0003;
  localparam logic [STOP_W-1:0] STOP_CONTOUR_BRAKING = 32'h0000_0004;

  // Safe operating mode encoding
  localparam logic [1:0] SAFE_MODE_ONE   = 2'h0;
  localparam logic [1:0] SAFE_MODE_TWO   = 2'h1;
  localparam logic [1:0] SAFE_MODE_THREE = 2'h2;
  localparam logic [1:0] SAFE_MODE_FOUR  = 2'h3;

  // Program-run idle timeout
  localparam int CLK_PERIOD_NS        = 20;
  localparam int RUN_CLEAR_TIME_MS    = 1000;
  localparam int RUN_CLEAR_CYCLES_DEF = (RUN_CLEAR_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int RUN_CNT_W            = 26;

  // All asynchronous pin inputs, sampled together
  typedef struct packed {
    logic                      spindle_guarded;      // Spindle space has a guard door
    logic                      nc_guarded;           // NC space has a guard door
    logic                      aux_guarded;          // Magazine space fully guarded
    logic                      single_spindle;       // Machine has one spindle
    logic                      confirm_required;     // Persons may stay in magazine
    logic                      spindle_door_closed;  // Main door closed
    logic                      nc_door_closed;       // All NC space doors closed
    logic                      magazine_door_closed; // Magazine door closed
    logic [1:0]                safe_mode;            // Safe operating mode
    logic                      handwheel_operation;  // 1 handwheel, 0 panel
    logic                      spindle_jog;
    logic                      spindle_start;
    logic                      nc_start;
    logic                      hw_permissive;        // Handwheel permissive
    logic                      panel_permissive;     // Operator panel permissive
    logic                      stop_key;
    logic                      ext_stop;             // External stop request
    logic                      magazine_permissive;
    logic                      magazine_confirm;     // Nobody-inside confirmation
    logic [MAG_KEY_COUNT-1:0]  magazine_motion_keys;
    logic [NC_AXIS_COUNT-1:0]  nc_dir_keys;
    logic [AUX_AXIS_COUNT-1:0] aux_dir_keys;
    logic                      nc_group_idle;        // Kernel reports no-motion state
  } pin_in_type;

endpackage : interlock_pkg

// file: include/pin_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
// Raw pin sample in, synchronised copy out
interface pin_bus_if;
  import interlock_pkg::*;
  pin_in_type raw;     // Straight from the pins
  pin_in_type synced;  // After two flip-flops
  modport sync_side (input raw, output synced);
  modport use_side  (output raw, input synced);
endinterface : pin_bus_if
`default_nettype wire

// file: verif/kernel_model.sv
`timescale 1ns/1ps
`default_nettype none
module kernel_model
  import interlock_pkg::*;
#(
  parameter int MAX_AXES = 3  // Kernel's own cap on moving NC axes
) (
  input  wire logic                               core_clk,
  input  wire logic                               sys_rst,
  input  wire logic [STOP_GROUPS-1:0][STOP_W-1:0] group_stop_request,
  input  wire logic [FEED_WIDTH-1:0]              axis_feed_permit,
  output logic      [STOP_GROUPS-1:0]             stop_latched,
  output logic                                    axes_limited
);
  // Any code but none latches the stop; a one-cycle request is enough
  // Ramps never finish here, so the latch only clears on reset
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) stop_latched <= '0;
    else for (int g = 0; g < STOP_GROUPS; g++)
      if (group_stop_request[g] !== STOP_NONE) stop_latched[g] <= 1'b1;
  end
  // Cap kept apart from the feed flags
  assign axes_limited = $countones(axis_feed_permit[7:0]) > MAX_AXES;
endmodule : kernel_model
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import interlock_pkg::*;
;
  logic                               core_clk = 1'b0;  // 50 MHz
  logic                               sys_rst  = 1'b1;
  pin_in_type                         p = '0;           // Pins as driven
  pin_in_type                         n;                // Next pin set
  logic [MOTION_GROUPS-1:0]           gmp;
  logic [FEED_WIDTH-1:0]              afp;
  logic [STOP_GROUPS-1:0][STOP_W-1:0] gsr;
  logic                               run;
  logic [STOP_GROUPS-1:0]             latched;
  int                                 err_count = 0;
  int                                 tests_run = 0;
  always #10 core_clk = ~core_clk;
  motion_permit_interlock #(.RUN_CLEAR_CYCLES(16)) i_motion_permit_interlock (
    .core_clk(core_clk), .sys_rst(sys_rst), .spindle_guarded(p.spindle_guarded),
    .nc_guarded(p.nc_guarded), .aux_guarded(p.aux_guarded),
    .single_spindle(p.single_spindle), .confirm_required(p.confirm_required),
    .spindle_door_closed(p.spindle_door_closed), .nc_door_closed(p.nc_door_closed),
    .magazine_door_closed(p.magazine_door_closed), .safe_mode(p.safe_mode),
    .handwheel_operation(p.handwheel_operation), .spindle_jog(p.spindle_jog),
    .spindle_start(p.spindle_start), .nc_start(p.nc_start),
    .hw_permissive(p.hw_permissive), .panel_permissive(p.panel_permissive),
    .stop_key(p.stop_key), .ext_stop(p.ext_stop),
    .magazine_permissive(p.magazine_permissive), .magazine_confirm(p.magazine_confirm),
    .magazine_motion_keys(p.magazine_motion_keys), .nc_dir_keys(p.nc_dir_keys),
    .aux_dir_keys(p.aux_dir_keys), .nc_group_idle(p.nc_group_idle),
    .group_motion_permit(gmp), .axis_feed_permit(afp), .group_stop_request(gsr),
    .program_run_flag(run));
  kernel_model i_kernel_model (.core_clk(core_clk), .sys_rst(sys_rst),
    .group_stop_request(gsr), .axis_feed_permit(afp), .stop_latched(latched),
    .axes_limited());
  // Expected NC feed flags when the space is open or closed
  function automatic logic [7:0] nc_exp(input pin_in_type q);
    if (q.nc_guarded && q.nc_door_closed) return 8'hff;
    return q.handwheel_operation ? {8{q.hw_permissive}} : q.nc_dir_keys;
  endfunction : nc_exp
  function automatic logic [3:0] aux_exp(input pin_in_type q);
    return (q.aux_guarded && q.magazine_door_closed) ? 4'hf : q.aux_dir_keys;
  endfunction : aux_exp
  // Unguarded spindle: needs mode two to four, source permissive, jog, one door shut
  function automatic logic sp_exp(input pin_in_type q);
    if (q.safe_mode == SAFE_MODE_ONE) return 1'b0;
    if (!q.spindle_door_closed && !q.magazine_door_closed) return 1'b0;
    return q.spindle_jog & (q.handwheel_operation ? q.hw_permissive : q.panel_permissive);
  endfunction : sp_exp
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : chk
  // Two sync flops plus the output register, so four edges is safe
  task automatic step;
    @(posedge core_clk);
    p <= n;
    repeat (4) @(posedge core_clk);
    #1;
  endtask : step
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // Watchdog against a hang
  initial begin
    #1000000;
    err_count++;
    complete_run();
  end
  initial begin
    void'($urandom(84501));
    n = '0;
    n.nc_group_idle = 1'b1;
    p <= n;
    repeat (3) @(posedge core_clk);
    for (int g = 0; g < STOP_GROUPS; g++) chk(gsr[g], STOP_CONTOUR_BRAKING, "reset stop");
    chk(32'(gmp) | 32'(afp), '0, "reset permits");
    sys_rst <= 1'b0;
    n.spindle_guarded = 1'b1;
    n.spindle_door_closed = 1'b1;
    step();
    chk(gmp[MPERM_SPINDLE], 1'b0, "guarded spindle idle");
    chk(latched, 3'h7, "kernel latch");
    n.spindle_jog = 1'b1;
    step();
    chk(gmp[MPERM_SPINDLE], 1'b1, "jog arms spindle");
    n.spindle_jog = 1'b0;
    step();
    chk(gmp[MPERM_SPINDLE], 1'b1, "spindle held");
    chk(gsr[STOP_SPINDLE], STOP_NONE, "guarded stop");
    n.spindle_door_closed = 1'b0;
    step();
    chk(gmp[MPERM_SPINDLE], 1'b0, "guarded door opened");
    n.spindle_door_closed = 1'b1;
    step();
    chk(gmp[MPERM_SPINDLE], 1'b0, "closing alone never arms");
    n.magazine_permissive = 1'b1;
    n.magazine_motion_keys = 4'h1 << ($urandom % 4);
    step();
    chk(gmp[MPERM_MAGAZINE], 1'b1, "one key");
    chk(gsr[STOP_MAGAZINE], STOP_NONE, "one key stop");
    n.magazine_motion_keys = 4'h3;
    step();
    chk(gmp[MPERM_MAGAZINE], 1'b0, "two keys");
    chk(gsr[STOP_MAGAZINE], STOP_CONTOUR_BRAKING, "two keys stop");
    n.magazine_door_closed = 1'b1;
    step();
    chk(gmp[MPERM_MAGAZINE], 1'b1, "magazine closed");
    n.confirm_required = 1'b1;
    step();
    chk(gmp[MPERM_MAGAZINE], 1'b0, "no confirmation");
    n.magazine_confirm = 1'b1;
    step();
    chk(gmp[MPERM_MAGAZINE], 1'b1, "confirmed");
    n.spindle_guarded = 1'b0;
    n.spindle_door_closed = 1'b0;
    n.safe_mode = SAFE_MODE_THREE;
    n.spindle_jog = 1'b1;
    n.panel_permissive = 1'b1;
    step();
    chk(gmp[MPERM_SPINDLE], 1'b1, "panel jog");
    n.handwheel_operation = 1'b1;
    step();
    chk(gmp[MPERM_SPINDLE], 1'b0, "no handwheel permissive");
    n.hw_permissive = 1'b1;
    n.safe_mode = SAFE_MODE_TWO;
    n.spindle_door_closed = 1'b1;
    step();
    chk(gmp[MPERM_SPINDLE], 1'b1, "handwheel jog");
    n.spindle_jog = 1'b0;
    n.spindle_start = 1'b1;
    step();
    chk(gmp[MPERM_SPINDLE], 1'b1, "start edge");
    n.spindle_start = 1'b0;
    n.spindle_jog = 1'b1;
    n.spindle_door_closed = 1'b0;
    n.magazine_door_closed = 1'b0;
    step();
    chk(gmp[MPERM_SPINDLE], 1'b0, "both doors open");
    n.nc_guarded = 1'b1;
    n.nc_door_closed = 1'b1;
    n.nc_group_idle = 1'b0;
    step();
    chk(afp[7:0], 8'hff, "nc closed");
    chk(run, 1'b1, "closed space runs");
    n.nc_guarded = 1'b0;
    n.nc_group_idle = 1'b1;
    step();
    chk(run, 1'b1, "short idle keeps run");
    repeat (12) @(posedge core_clk);
    #1;
    chk(run, 1'b1, "run held before timeout");
    repeat (4) @(posedge core_clk);
    #1;
    chk(run, 1'b0, "idle clears run");
    for (int i = 0; i < 32; i++) begin
      {n.nc_door_closed, n.handwheel_operation, n.hw_permissive, n.nc_dir_keys,
       n.aux_guarded, n.magazine_door_closed, n.aux_dir_keys, n.single_spindle,
       n.safe_mode, n.spindle_door_closed} = 21'($urandom);
      step();
      chk(afp[7:0], nc_exp(n), "nc feed");
      chk(afp[22:19], aux_exp(n), "aux feed");
      chk(gmp[MPERM_SPINDLE], sp_exp(n), "spindle permit");
      chk(afp[SPINDLE_FEED_IDX], n.single_spindle | sp_exp(n), "spindle feed");
    end
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
